// >>> irq_priority_cfg.svh
// Constants for the interrupt priority register pair
`ifndef IRQ_PRIORITY_CFG_SVH
`define IRQ_PRIORITY_CFG_SVH

// ==========================================
// Bus geometry
`define PRIO_ADDR_W        12
`define PRIO_DATA_W        32
`define PRIO_REG_W         16
`define PRIO_NUM_SRC       2

// ==========================================
// Register byte offsets
`define PRIO_OFS_COMPARE5  12'h000
`define PRIO_OFS_PARALLEL  12'h004

// ==========================================
// Priority field layout and values
`define PRIO_FIELD_MSB     6
`define PRIO_FIELD_LSB     4
`define PRIO_RESET_VALUE   3'h4
`define PRIO_DISABLED      3'h0

`endif

// >>> irq_priority_pkg.sv
// Types shared by the interrupt priority register pair
`default_nettype none
package irq_priority_pkg;
   typedef logic [2:0] prio_level_t;
   typedef enum logic [0:0] {
      SRC_COMPARE5 = 1'b0,
      SRC_PARALLEL = 1'b1
   } src_sel_t;
endpackage
`default_nettype wire

// >>> priority_field_reg.sv
// One 16-bit priority register holding a 3-bit level field
`include "irq_priority_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module priority_field_reg
   import irq_priority_pkg::*;
(
   input  wire logic                   clk_sys,
   input  wire logic                   srst,
   input  wire logic                   wrEn,
   input  wire logic [`PRIO_REG_W-1:0] wrData,
   output var  logic [2:0]             levelQ,
   output var  logic                   enabledQ,
   output var  logic [`PRIO_REG_W-1:0] readValue
);

   logic [2:0] levelD;
   logic       enabledD;

   // ==========================================
   // Next state
   always_comb begin
      levelD = levelQ;
      if (wrEn) begin
         levelD = wrData[`PRIO_FIELD_MSB:`PRIO_FIELD_LSB];
      end
      if (srst) begin
         levelD = `PRIO_RESET_VALUE;
      end
      enabledD = (levelD != `PRIO_DISABLED);
   end

   always_ff @(posedge clk_sys) begin
      levelQ   <= levelD;
      enabledQ <= enabledD;
   end

   // ==========================================
   // Readback
   always_comb begin
      readValue = '0;
      readValue[`PRIO_FIELD_MSB:`PRIO_FIELD_LSB] = levelQ;
   end

   // ==========================================
   // Checks
   chk_hold_no_write: assert property (@(posedge clk_sys) disable iff (srst)
      !wrEn |=> $stable(levelQ))
      else $error("Level changed without a write");

   chk_enable_tracks: assert property (@(posedge clk_sys) disable iff (srst)
      enabledQ == (levelQ != `PRIO_DISABLED))
      else $error("Enable flag disagrees with level");

   chk_reset_level: assert property (@(posedge clk_sys)
      srst |=> (levelQ == `PRIO_RESET_VALUE) && enabledQ)
      else $error("Level not four after reset");

endmodule
`default_nettype wire

// >>> irq_priority_regs_10_11.sv
// APB priority registers for compare channel 5 and parallel port
`include "irq_priority_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Compare channel 5 level in bits 6..4
// - Parallel port level in bits 6..4
// - Levels 1..7 rank, seven highest
// - Level zero disables the source
// - Other bits read zero, writes ignored
module irq_priority_regs_10_11
   import irq_priority_pkg::*;
#(
   parameter int ADDR_W = `PRIO_ADDR_W
) (
   input  wire logic                    clk_sys,
   input  wire logic                    srst,
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [ADDR_W-1:0]       paddr,
   input  wire logic [`PRIO_DATA_W-1:0] pwdata,
   output var  logic [`PRIO_DATA_W-1:0] prdata,
   output var  logic                    pready,
   output var  logic                    pslverr,
   input  wire logic                    compareCh5Pending,
   input  wire logic                    parallelPortPending,
   output var  logic [2:0]              compareCh5IrqLevel,
   output var  logic [2:0]              parallelPortIrqLevel,
   output var  logic                    compareCh5IrqEnabled,
   output var  logic                    parallelPortIrqEnabled,
   output var  logic                    irqRequest,
   output var  logic [2:0]              irqWinnerLevel,
   output var  logic                    irqWinnerSrc
);

   localparam int NUM_SRC = `PRIO_NUM_SRC;
   localparam logic [ADDR_W-1:0] SRC_OFS [NUM_SRC] = '{
      ADDR_W'(`PRIO_OFS_COMPARE5),
      ADDR_W'(`PRIO_OFS_PARALLEL)
   };

   logic [NUM_SRC-1:0]      hitVec;
   logic [NUM_SRC-1:0]      wrEnVec;
   logic [NUM_SRC-1:0]      enabledVec;
   logic [NUM_SRC-1:0]      pendingVec;
   logic [NUM_SRC-1:0]      candVec;
   prio_level_t             levelArr [NUM_SRC];
   logic [`PRIO_REG_W-1:0]  readArr  [NUM_SRC];

   logic                    preadyQ;
   logic                    preadyD;
   logic [`PRIO_DATA_W-1:0] prdataQ;
   logic [`PRIO_DATA_W-1:0] prdataD;
   logic                    pslverrQ;
   logic                    pslverrD;
   logic                    accessNew;
   logic                    accessDone;
   logic                    anyHit;
   logic [`PRIO_REG_W-1:0]  readMux;

   logic                    irqRequestQ;
   logic                    irqRequestD;
   prio_level_t             winLevelQ;
   prio_level_t             winLevelD;
   src_sel_t                winSrcQ;
   src_sel_t                winSrcD;

   assign pendingVec = {parallelPortPending, compareCh5Pending};

   // ==========================================
   // Per-source registers
   for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
      assign hitVec[i]  = (paddr == SRC_OFS[i]);
      assign wrEnVec[i] = accessDone && pwrite && hitVec[i];
      assign candVec[i] = pendingVec[i] && enabledVec[i];

      priority_field_reg u_field (
         .clk_sys   (clk_sys),
         .srst      (srst),
         .wrEn      (wrEnVec[i]),
         .wrData    (pwdata[`PRIO_REG_W-1:0]),
         .levelQ    (levelArr[i]),
         .enabledQ  (enabledVec[i]),
         .readValue (readArr[i])
      );
   end

   // ==========================================
   // APB slave, one wait state
   assign accessNew  = psel && penable && !preadyQ;
   assign accessDone = psel && penable && preadyQ;
   assign anyHit     = |hitVec;

   always_comb begin
      readMux = '0;
      for (int k = 0; k < NUM_SRC; k++) begin
         if (hitVec[k]) begin
            readMux = readArr[k];
         end
      end
   end

   always_comb begin
      preadyD  = 1'b0;
      prdataD  = 32'h0000_0000;
      pslverrD = 1'b0;
      if (accessNew) begin
         preadyD  = 1'b1;
         pslverrD = !anyHit;
         if (!pwrite) begin
            prdataD = {16'h0000, readMux};
         end
      end
      if (srst) begin
         preadyD  = 1'b0;
         prdataD  = 32'h0000_0000;
         pslverrD = 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      preadyQ  <= preadyD;
      prdataQ  <= prdataD;
      pslverrQ <= pslverrD;
   end

   // ==========================================
   // Priority selection
   always_comb begin
      irqRequestD = 1'b0;
      winLevelD   = `PRIO_DISABLED;
      winSrcD     = SRC_COMPARE5;
      // Higher level wins, tie to compare
      if (candVec[SRC_COMPARE5] && candVec[SRC_PARALLEL]) begin
         irqRequestD = 1'b1;
         if (levelArr[SRC_PARALLEL] > levelArr[SRC_COMPARE5]) begin
            winLevelD = levelArr[SRC_PARALLEL];
            winSrcD   = SRC_PARALLEL;
         end else begin
            winLevelD = levelArr[SRC_COMPARE5];
         end
      end else if (candVec[SRC_COMPARE5]) begin
         irqRequestD = 1'b1;
         winLevelD   = levelArr[SRC_COMPARE5];
      end else if (candVec[SRC_PARALLEL]) begin
         irqRequestD = 1'b1;
         winLevelD   = levelArr[SRC_PARALLEL];
         winSrcD     = SRC_PARALLEL;
      end
      if (srst) begin
         irqRequestD = 1'b0;
         winLevelD   = `PRIO_DISABLED;
         winSrcD     = SRC_COMPARE5;
      end
   end

   always_ff @(posedge clk_sys) begin
      irqRequestQ <= irqRequestD;
      winLevelQ   <= winLevelD;
      winSrcQ     <= winSrcD;
   end

   // ==========================================
   // Outputs
   assign prdata                 = prdataQ;
   assign pready                 = preadyQ;
   assign pslverr                = pslverrQ;
   assign compareCh5IrqLevel     = levelArr[SRC_COMPARE5];
   assign parallelPortIrqLevel   = levelArr[SRC_PARALLEL];
   assign compareCh5IrqEnabled   = enabledVec[SRC_COMPARE5];
   assign parallelPortIrqEnabled = enabledVec[SRC_PARALLEL];
   assign irqRequest             = irqRequestQ;
   assign irqWinnerLevel         = winLevelQ;
   assign irqWinnerSrc           = winSrcQ;

   // ==========================================
   // Checks
   chk_write_compare: assert property (@(posedge clk_sys) disable iff (srst)
      (accessDone && pwrite && paddr == SRC_OFS[SRC_COMPARE5])
      |=> compareCh5IrqLevel == $past(pwdata[`PRIO_FIELD_MSB:`PRIO_FIELD_LSB]))
      else $error("Compare level not written");

   chk_write_parallel: assert property (@(posedge clk_sys) disable iff (srst)
      (accessDone && pwrite && paddr == SRC_OFS[SRC_PARALLEL])
      |=> parallelPortIrqLevel == $past(pwdata[`PRIO_FIELD_MSB:`PRIO_FIELD_LSB]))
      else $error("Parallel level not written");

   chk_read_zeros: assert property (@(posedge clk_sys) disable iff (srst)
      (pready && !pwrite) |-> (prdata[`PRIO_DATA_W-1:`PRIO_FIELD_MSB+1] == '0)
      && (prdata[`PRIO_FIELD_LSB-1:0] == '0))
      else $error("Unused read bits not zero");

   chk_read_level: assert property (@(posedge clk_sys) disable iff (srst)
      (accessNew && !pwrite && paddr == SRC_OFS[SRC_COMPARE5])
      |=> prdata[`PRIO_FIELD_MSB:`PRIO_FIELD_LSB] == $past(compareCh5IrqLevel))
      else $error("Compare readback wrong");

   chk_higher_wins: assert property (@(posedge clk_sys) disable iff (srst)
      (candVec[SRC_COMPARE5] && candVec[SRC_PARALLEL]
       && levelArr[SRC_PARALLEL] > levelArr[SRC_COMPARE5])
      |=> irqRequest && irqWinnerSrc == SRC_PARALLEL
      && irqWinnerLevel == $past(levelArr[SRC_PARALLEL]))
      else $error("Higher level did not win");

   chk_disabled_silent: assert property (@(posedge clk_sys) disable iff (srst)
      (levelArr[SRC_COMPARE5] == `PRIO_DISABLED && levelArr[SRC_PARALLEL] == `PRIO_DISABLED)
      |=> !irqRequest)
      else $error("Request from disabled sources");

   chk_one_wait: assert property (@(posedge clk_sys) disable iff (srst)
      accessNew |=> pready ##1 !pready)
      else $error("Ready timing wrong");

   chk_reset_out: assert property (@(posedge clk_sys)
      srst |=> compareCh5IrqLevel == `PRIO_RESET_VALUE
      && parallelPortIrqLevel == `PRIO_RESET_VALUE && !pready && !irqRequest)
      else $error("Reset values wrong");

endmodule
`default_nettype wire

// >>> tb.sv
// Self-checking testbench for the interrupt priority register pair
`timescale 1ns/1ps
`default_nettype none
`include "irq_priority_cfg.svh"
module tb
   import irq_priority_pkg::*;
;
   logic        clk_sys;
   logic        srst;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        cmpPending;
   logic        parPending;
   logic [2:0]  cmpLevel;
   logic [2:0]  parLevel;
   logic        cmpEnabled;
   logic        parEnabled;
   logic        irqRequest;
   logic [2:0]  winLevel;
   logic        winSrc;
   int          errorCnt;
   int          checkCount;
   logic [31:0] rd;
   logic        err;

   irq_priority_regs_10_11 irq_priority_regs_10_11_inst (
      .clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .compareCh5Pending(cmpPending), .parallelPortPending(parPending),
      .compareCh5IrqLevel(cmpLevel), .parallelPortIrqLevel(parLevel),
      .compareCh5IrqEnabled(cmpEnabled), .parallelPortIrqEnabled(parEnabled),
      .irqRequest(irqRequest), .irqWinnerLevel(winLevel), .irqWinnerSrc(winSrc));

   // ==========================================
   // Clock and shared tasks
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   task automatic summarize();
      if (errorCnt == 0 && checkCount > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checkCount++;
      if (got !== exp) begin
         errorCnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
      @(posedge clk_sys);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= addr;
      pwdata  <= data;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1) begin
         @(posedge clk_sys);
      end
      rd      = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdchk(input logic [11:0] addr, input logic [31:0] exp, input logic expErr);
      apb(1'b0, addr, 32'h0000_0000);
      chk("prdata", exp, rd);
      chk("pslverr", 32'(expErr), 32'(err));
   endtask

   task automatic pend(input logic c, input logic p);
      @(posedge clk_sys);
      cmpPending <= c;
      parPending <= p;
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask

   // ==========================================
   // Scenarios
   task automatic test_reset();
      rdchk(`PRIO_OFS_COMPARE5, 32'h0000_0040, 1'b0);
      rdchk(`PRIO_OFS_PARALLEL, 32'h0000_0040, 1'b0);
      chk("levels", 32'h0000_0044, {24'h00_0000, 1'b0, cmpLevel, 1'b0, parLevel});
      chk("enables", 32'h0000_0003, 32'({cmpEnabled, parEnabled}));
   endtask

   task automatic test_mask();
      apb(1'b1, `PRIO_OFS_COMPARE5, 32'hFFFF_FFFF);
      apb(1'b1, `PRIO_OFS_PARALLEL, 32'hFFFF_FF8F);
      rdchk(`PRIO_OFS_COMPARE5, 32'h0000_0070, 1'b0);
      rdchk(`PRIO_OFS_PARALLEL, 32'h0000_0000, 1'b0);
      chk("cmpLevel", 32'h0000_0007, 32'(cmpLevel));
      chk("parEnabled", 32'h0000_0000, 32'(parEnabled));
   endtask

   task automatic test_disable();
      apb(1'b1, `PRIO_OFS_COMPARE5, 32'h0000_0000);
      pend(1'b1, 1'b1);
      chk("irqRequest off", 32'h0000_0000, 32'(irqRequest));
      apb(1'b1, `PRIO_OFS_PARALLEL, 32'h0000_0010);
      rdchk(`PRIO_OFS_PARALLEL, 32'h0000_0010, 1'b0);
      pend(1'b1, 1'b1);
      chk("irqRequest on", 32'h0000_0001, 32'(irqRequest));
      chk("winner", 32'({1'b1, 3'h1}), 32'({winSrc, winLevel}));
      pend(1'b0, 1'b0);
   endtask

   task automatic test_levels();
      logic [2:0] lv;
      logic       s;
      for (int l = 1; l <= 7; l++) begin
         lv = 3'(l);
         s  = (l < 4) ? SRC_PARALLEL : SRC_COMPARE5;
         apb(1'b1, `PRIO_OFS_COMPARE5, 32'({lv, 4'h0}));
         apb(1'b1, `PRIO_OFS_PARALLEL, 32'({3'(8 - l), 4'h0}));
         pend(1'b1, 1'b1);
         chk("winner", 32'({s, (s ? 3'(8 - l) : lv)}), 32'({winSrc, winLevel}));
      end
      pend(1'b0, 1'b0);
   endtask

   task automatic test_unmapped();
      rdchk(12'h008, 32'h0000_0000, 1'b1);
      apb(1'b1, 12'h001, 32'h0000_0000);
      chk("pslverr", 32'h0000_0001, 32'(err));
      rdchk(`PRIO_OFS_COMPARE5, 32'h0000_0070, 1'b0);
   endtask

   task automatic test_midreset();
      apb(1'b1, `PRIO_OFS_PARALLEL, 32'h0000_0070);
      @(posedge clk_sys);
      srst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      srst <= 1'b0;
      @(posedge clk_sys);
      rdchk(`PRIO_OFS_COMPARE5, 32'h0000_0040, 1'b0);
      rdchk(`PRIO_OFS_PARALLEL, 32'h0000_0040, 1'b0);
      chk("parLevel", 32'h0000_0004, 32'(parLevel));
      chk("irqRequest rst", 32'h0000_0000, 32'(irqRequest));
   endtask

   // ==========================================
   // Main sequence and watchdog
   initial begin
      srst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      cmpPending = 1'b0;
      parPending = 1'b0;
      errorCnt = 0;
      checkCount = 0;
      repeat (12) @(posedge clk_sys);
      srst <= 1'b0;
      @(posedge clk_sys);
      test_reset();
      test_mask();
      test_disable();
      test_levels();
      test_unmapped();
      test_midreset();
      summarize();
   end

   initial begin
      #100000;
      errorCnt++;
      summarize();
   end
endmodule
`default_nettype wire
